// *** hw/cpu_prog_model.v ***
// Programming-model registers, flag logic, interrupt stacking and low-power control
// Notes on behaviour
// - Index pair is 16 bits, upper and lower byte, readable and loadable.
// - Reset loads stack pointer with 00FF.
// - Reset-stack-pointer sets low byte FF, keeps high byte.
// - Stack pointer decrements per push, increments per pull.
// - Stack-offset address equals stack pointer plus offset.
// - Program counter increments on fetch; jumps and interrupts load it.
// - After reset the program counter loads from FFFE high, FFFF low.
// - Condition code bits 6 and 5 always read one.
// - Overflow set on two's complement overflow, cleared otherwise; decimal adjust here leaves it unchanged.
// - Half carry captures bit 3 carry on add; decimal adjust uses it.
// - Mask blocks maskable requests; set after stacking, before vector fetch.
// - Interrupt entry does not stack the upper index byte.
// - Highest-priority pending request is taken first.
// - Return from interrupt pulls condition codes, accumulator, index low, counter.
// - Reset sets the mask; otherwise only clear-mask, return or low power clear it.
// - Negative flag copies result bit 7.
// - Zero flag set exactly when result is 00.
// - Carry set on carry out of bit 7 or borrow; shifts update it.
// - Wait clears mask and gates clock; interrupt wake stacks the mask clear, then sets it.
// - Stop clears mask, gates clock; wake waits oscillator stabilisation.
// - Break loads software-interrupt opcode; vector FFFC or FEFC in monitor.
// - Break starts at instruction end; return resumes only once break drops.
// - Eight-bit accumulator feeds and receives arithmetic results.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "cpu_prog_model_regs.vh"
module cpu_prog_model #(
  parameter NIRQ = 4,
  parameter STAB_CYCLES = `STAB_CYCLES,
  parameter [NIRQ-1:0] STOP_WAKE_MASK = 1
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Execution unit commands
  output wire exec_ready,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire [15:0] cmd_data,
  input wire alu_valid,
  input wire [2:0] alu_op,
  input wire [7:0] alu_operand,
  input wire insn_end,
  input wire ea_req,
  input wire [15:0] ea_offset,
  output reg [15:0] ea_addr,
  // Memory port for stacking and vectors
  output wire mem_req,
  output wire mem_we,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  // Interrupt, break and mode sources
  input wire [NIRQ-1:0] irq_pending,
  input wire brk_match,
  input wire monitor_mode,
  // Core controls
  output wire cpu_clk_en,
  output reg load_swi_ir,
  output wire [7:0] swi_opcode
);

  localparam S_RVEC = 8'h01;
  localparam S_RUN = 8'h02;
  localparam S_STACK = 8'h04;
  localparam S_VEC = 8'h08;
  localparam S_PULL = 8'h10;
  localparam S_LOWP = 8'h20;
  localparam S_STAB = 8'h40;
  localparam S_BHOLD = 8'h80;
  localparam [15:0] STAB_N = STAB_CYCLES;

  reg [7:0] state_q;
  reg [7:0] h_q;
  reg [7:0] x_q;
  reg [7:0] a_q;
  reg [15:0] sp_q;
  reg [15:0] pc_q;
  reg v_q, hc_q, i_q, n_q, z_q, c_q;
  reg [2:0] step_q;
  reg [15:0] vec_q;
  reg stop_q;
  reg brk_pend_q;
  reg brk_active_q;
  reg [15:0] stab_q;

  wire [7:0] condition_codes = {v_q, 1'b1, 1'b1, hc_q, i_q, n_q, z_q, c_q};
  wire run = (state_q == S_RUN);
  assign exec_ready = run;
  assign cpu_clk_en = (state_q != S_LOWP) && (state_q != S_STAB);
  assign swi_opcode = `OPC_SWI;

  // Highest-priority pending request: lowest index wins
  reg irq_any;
  reg [15:0] irq_vec;
  integer k;
  always @* begin
    irq_any = 1'b0;
    irq_vec = `VEC_IRQ_TOP;
    for (k = NIRQ - 1; k >= 0; k = k - 1) begin
      if (irq_pending[k]) begin
        irq_any = 1'b1;
        irq_vec = `VEC_IRQ_TOP - {k[14:0], 1'b0};
      end
    end
  end

  wire brk_req = brk_match || brk_pend_q;
  wire take_brk = run && insn_end && brk_req && !brk_active_q;
  wire take_irq = run && insn_end && irq_any && !i_q;
  wire [15:0] brk_vec = monitor_mode ? `VEC_SWI_MON : `VEC_SWI;
  wire [NIRQ-1:0] stop_wake = irq_pending & STOP_WAKE_MASK;

  assign mem_req = (state_q == S_RVEC) || (state_q == S_STACK) ||
                   (state_q == S_VEC) || (state_q == S_PULL);
  assign mem_we = (state_q == S_STACK);

  // Address and write byte for the current step
  always @* begin
    mem_addr = sp_q;
    mem_wdata = 8'h00;
    case (state_q)
      S_RVEC: mem_addr = `VEC_RESET + {15'd0, step_q[0]};
      S_VEC: mem_addr = vec_q + {15'd0, step_q[0]};
      S_PULL: mem_addr = sp_q + 16'h0001;
      S_STACK: begin
        mem_addr = sp_q;
        // Frame omits the upper index byte
        case (step_q)
          3'd0: mem_wdata = pc_q[7:0];
          3'd1: mem_wdata = pc_q[15:8];
          3'd2: mem_wdata = x_q;
          3'd3: mem_wdata = a_q;
          default: mem_wdata = condition_codes;
        endcase
      end
      default: mem_addr = sp_q;
    endcase
  end

  // Arithmetic results and flags
  reg [8:0] sum;
  reg [4:0] nib;
  reg [7:0] res;
  reg fv, fh, fc, wr_h;
  reg [7:0] corr;
  always @* begin
    sum = 9'd0;
    nib = 5'd0;
    res = 8'h00;
    fv = v_q;
    fh = hc_q;
    fc = c_q;
    wr_h = 1'b0;
    corr = 8'h00;
    case (alu_op)
      `ALU_ADD, `ALU_ADC: begin
        sum = {1'b0, a_q} + {1'b0, alu_operand} +
              {8'd0, (alu_op == `ALU_ADC) & c_q};
        nib = {1'b0, a_q[3:0]} + {1'b0, alu_operand[3:0]} +
              {4'd0, (alu_op == `ALU_ADC) & c_q};
        res = sum[7:0];
        fc = sum[8];
        fh = nib[4];
        wr_h = 1'b1;
        fv = (a_q[7] == alu_operand[7]) && (res[7] != a_q[7]);
      end
      `ALU_SUB, `ALU_SBC: begin
        sum = {1'b0, a_q} - {1'b0, alu_operand} -
              {8'd0, (alu_op == `ALU_SBC) & c_q};
        res = sum[7:0];
        fc = sum[8];
        fv = (a_q[7] != alu_operand[7]) && (res[7] != a_q[7]);
      end
      `ALU_AND: begin
        res = a_q & alu_operand;
        fv = 1'b0;
      end
      `ALU_ORA: begin
        res = a_q | alu_operand;
        fv = 1'b0;
      end
      `ALU_LSL: begin
        res = {a_q[6:0], 1'b0};
        fc = a_q[7];
        fv = a_q[7] ^ a_q[6];
      end
      default: begin
        // Decimal adjust picks its correction from half carry and carry
        if (hc_q || (a_q[3:0] > 4'h9))
          corr[3:0] = 4'h6;
        if (c_q || (a_q > 8'h99)) begin
          corr[7:4] = 4'h6;
          fc = 1'b1;
        end
        res = a_q + corr;
      end
    endcase
  end

  // APB decode; the bus never stalls
  wire apb_wr = psel && penable && pwrite;
  reg map_hit;
  always @* begin
    map_hit = 1'b1;
    case (paddr)
      `OFS_INDEX_PAIR: prdata = {16'h0000, h_q, x_q};
      `OFS_STACK_PTR: prdata = {16'h0000, sp_q};
      `OFS_PROG_CNT: prdata = {16'h0000, pc_q};
      `OFS_COND_CODES: prdata = {24'h000000, condition_codes};
      `OFS_ACCUM: prdata = {24'h000000, a_q};
      `OFS_STATUS: prdata = {20'h00000, brk_active_q, stop_q, 2'b00, state_q};
      default: begin
        prdata = 32'h00000000;
        map_hit = 1'b0;
      end
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;

  // Register and sequence state; execution writes take precedence over APB
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_RVEC;
      h_q <= 8'h00;
      x_q <= 8'h00;
      a_q <= 8'h00;
      sp_q <= `SP_RESET;
      pc_q <= 16'h0000;
      v_q <= 1'b0;
      hc_q <= 1'b0;
      i_q <= 1'b1;
      n_q <= 1'b0;
      z_q <= 1'b0;
      c_q <= 1'b0;
      step_q <= 3'd0;
      vec_q <= `VEC_RESET;
      stop_q <= 1'b0;
      brk_pend_q <= 1'b0;
      brk_active_q <= 1'b0;
      stab_q <= 16'h0000;
      ea_addr <= 16'h0000;
      load_swi_ir <= 1'b0;
    end else begin
      load_swi_ir <= 1'b0;
      if (ea_req)
        ea_addr <= sp_q + ea_offset;
      // A match inside an instruction waits for its end
      if (brk_match && !brk_active_q && !take_brk)
        brk_pend_q <= 1'b1;
      if (apb_wr) begin
        case (paddr)
          `OFS_INDEX_PAIR: {h_q, x_q} <= pwdata[15:0];
          `OFS_STACK_PTR: sp_q <= pwdata[15:0];
          `OFS_PROG_CNT: pc_q <= pwdata[15:0];
          `OFS_ACCUM: a_q <= pwdata[7:0];
          `OFS_COND_CODES: begin
            {v_q, hc_q, n_q, z_q, c_q} <= {pwdata[7], pwdata[4], pwdata[2:0]};
            // Software may set the mask here but only clear-mask, return or low power clear it
            i_q <= i_q | pwdata[3];
          end
          default: h_q <= h_q;
        endcase
      end
      case (state_q)
        S_RVEC: if (mem_ack) begin
          if (step_q[0]) begin
            pc_q[7:0] <= mem_rdata;
            step_q <= 3'd0;
            state_q <= S_RUN;
          end else begin
            pc_q[15:8] <= mem_rdata;
            step_q <= 3'd1;
          end
        end
        S_RUN: begin
          if (alu_valid) begin
            a_q <= res;
            n_q <= res[7];
            z_q <= (res == 8'h00);
            v_q <= fv;
            c_q <= fc;
            if (wr_h)
              hc_q <= fh;
          end
          if (cmd_valid) begin
            case (cmd_code)
              `CMD_LD_HX: {h_q, x_q} <= cmd_data;
              `CMD_LD_SP: sp_q <= cmd_data;
              `CMD_RSP: sp_q[7:0] <= `SP_LOW_RESET;
              `CMD_PUSH: sp_q <= sp_q - 16'h0001;
              `CMD_PULL: sp_q <= sp_q + 16'h0001;
              `CMD_FETCH: pc_q <= pc_q + 16'h0001;
              `CMD_JUMP: pc_q <= cmd_data;
              `CMD_CLI: i_q <= 1'b0;
              `CMD_SEI: i_q <= 1'b1;
              `CMD_LD_CC: begin
                {v_q, hc_q, n_q, z_q, c_q} <= {cmd_data[7], cmd_data[4], cmd_data[2:0]};
                i_q <= i_q | cmd_data[3];
              end
              `CMD_LD_A: a_q <= cmd_data[7:0];
              `CMD_RTI: begin
                step_q <= 3'd0;
                state_q <= S_PULL;
              end
              `CMD_WAIT, `CMD_STOP: begin
                i_q <= 1'b0;
                stop_q <= (cmd_code == `CMD_STOP);
                state_q <= S_LOWP;
              end
              `CMD_SWI: begin
                vec_q <= `VEC_SWI;
                step_q <= 3'd0;
                state_q <= S_STACK;
              end
              default: state_q <= S_RUN;
            endcase
          end
          // Break is not maskable and outranks maskable requests
          if (take_brk) begin
            load_swi_ir <= 1'b1;
            brk_pend_q <= 1'b0;
            brk_active_q <= 1'b1;
            vec_q <= brk_vec;
            step_q <= 3'd0;
            state_q <= S_STACK;
          end else if (take_irq) begin
            vec_q <= irq_vec;
            step_q <= 3'd0;
            state_q <= S_STACK;
          end
        end
        S_STACK: if (mem_ack) begin
          sp_q <= sp_q - 16'h0001;
          if (step_q == `FRAME_BYTES - 3'd1) begin
            i_q <= 1'b1;
            step_q <= 3'd0;
            state_q <= S_VEC;
          end else begin
            step_q <= step_q + 3'd1;
          end
        end
        S_VEC: if (mem_ack) begin
          if (step_q[0]) begin
            pc_q[7:0] <= mem_rdata;
            step_q <= 3'd0;
            state_q <= S_RUN;
          end else begin
            pc_q[15:8] <= mem_rdata;
            step_q <= 3'd1;
          end
        end
        S_PULL: if (mem_ack) begin
          sp_q <= sp_q + 16'h0001;
          step_q <= step_q + 3'd1;
          case (step_q)
            3'd0: begin
              {v_q, hc_q, n_q, z_q, c_q} <= {mem_rdata[7], mem_rdata[4], mem_rdata[2:0]};
              i_q <= mem_rdata[3];
            end
            3'd1: a_q <= mem_rdata;
            3'd2: x_q <= mem_rdata;
            3'd3: pc_q[15:8] <= mem_rdata;
            default: begin
              pc_q[7:0] <= mem_rdata;
              step_q <= 3'd0;
              // Break stays in force while its request is still held
              if (brk_active_q && brk_match) begin
                state_q <= S_BHOLD;
              end else begin
                brk_active_q <= 1'b0;
                state_q <= S_RUN;
              end
            end
          endcase
        end
        S_BHOLD: if (!brk_match) begin
          brk_active_q <= 1'b0;
          brk_pend_q <= 1'b0;
          state_q <= S_RUN;
        end
        S_LOWP: begin
          // Stop only wakes on external lines; wait wakes on any request
          if (stop_q && (stop_wake != {NIRQ{1'b0}})) begin
            stab_q <= STAB_N;
            state_q <= S_STAB;
          end else if (!stop_q && irq_any) begin
            vec_q <= irq_vec;
            step_q <= 3'd0;
            state_q <= S_STACK;
          end
        end
        S_STAB: begin
          if (stab_q <= 16'h0001) begin
            stop_q <= 1'b0;
            vec_q <= irq_vec;
            step_q <= 3'd0;
            state_q <= S_STACK;
          end else begin
            stab_q <= stab_q - 16'h0001;
          end
        end
        default: state_q <= S_RVEC;
      endcase
    end
  end

endmodule

// *** hw/cpu_prog_model_regs.vh ***
// Register offsets, field positions, codes and timing for the programming model
`ifndef CPU_PROG_MODEL_REGS_VH
`define CPU_PROG_MODEL_REGS_VH
// APB byte offsets
`define OFS_INDEX_PAIR 8'h00
`define OFS_STACK_PTR 8'h04
`define OFS_PROG_CNT 8'h08
`define OFS_COND_CODES 8'h0C
`define OFS_ACCUM 8'h10
`define OFS_STATUS 8'h14
// Reset values and vectors
`define SP_RESET 16'h00FF
`define SP_LOW_RESET 8'hFF
`define VEC_RESET 16'hFFFE
`define VEC_SWI 16'hFFFC
`define VEC_SWI_MON 16'hFEFC
`define VEC_IRQ_TOP 16'hFFFA
`define OPC_SWI 8'h83
// Condition code bit positions
`define CC_C 0
`define CC_Z 1
`define CC_N 2
`define CC_I 3
`define CC_H 4
`define CC_V 7
// Execution commands
`define CMD_LD_HX 4'h1
`define CMD_LD_SP 4'h2
`define CMD_RSP 4'h3
`define CMD_PUSH 4'h4
`define CMD_PULL 4'h5
`define CMD_FETCH 4'h6
`define CMD_JUMP 4'h7
`define CMD_CLI 4'h8
`define CMD_SEI 4'h9
`define CMD_LD_CC 4'hA
`define CMD_RTI 4'hB
`define CMD_WAIT 4'hC
`define CMD_STOP 4'hD
`define CMD_SWI 4'hE
`define CMD_LD_A 4'hF
// ALU operations
`define ALU_ADD 3'h0
`define ALU_ADC 3'h1
`define ALU_SUB 3'h2
`define ALU_SBC 3'h3
`define ALU_AND 3'h4
`define ALU_ORA 3'h5
`define ALU_LSL 3'h6
`define ALU_DAA 3'h7
// Stacked bytes per interrupt frame
`define FRAME_BYTES 3'd5
// Oscillator stabilisation after stop, in cycles
`define STAB_CYCLES 4096
`endif

// *** test/mem_partner.sv ***
// Memory seen by the stacking and vector port, with a prompt or slow answer
`timescale 1ns/1ns
module mem_partner (
  // Clock, reset and pacing
  input wire pclk,
  input wire presetn,
  input wire slow,
  // Memory port
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg mem_ack,
  output reg [7:0] mem_rdata
);
  reg [7:0] ram [0:65535];
  reg [1:0] wait_q;
  integer i;
  initial begin
    for (i = 0; i < 65536; i = i + 1) begin
      ram[i] = 8'h00;
    end
    ram[16'hFFFE] = 8'h40;
    ram[16'hFFF8] = 8'h51;
    ram[16'hFFF4] = 8'h52;
    ram[16'hFFFA] = 8'h53;
    ram[16'hFEFC] = 8'h60;
    ram[16'hFFFC] = 8'h70;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 8'h00;
    end else if (mem_req && !mem_ack && wait_q == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      mem_rdata <= ram[mem_addr];
    end else begin
      // Read data is only valid with the acknowledge, so scramble it otherwise
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_q <= wait_q + 2'h1;
      end
      if (mem_req && mem_ack && mem_we) begin
        ram[mem_addr] <= mem_wdata;
      end
    end
  end
endmodule

// *** test/cpu_prog_model_properties.sv ***
// Concurrent checks on the programming-model ports
`timescale 1ns/1ns
`include "cpu_prog_model_regs.vh"
module cpu_prog_model_properties (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  // Execution side
  input wire exec_ready,
  input wire cmd_valid,
  input wire [3:0] cmd_code,
  input wire insn_end,
  input wire brk_match,
  input wire monitor_mode,
  // Memory port
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr,
  input wire mem_ack,
  // Core controls
  input wire cpu_clk_en,
  input wire load_swi_ir,
  input wire [7:0] swi_opcode
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_ack;
    mem_req && mem_ack && mem_we;
  endsequence
  sequence s_rd_ack;
    mem_req && mem_ack && !mem_we;
  endsequence
  a_ccr_fixed_ones: assert property (
    psel && !pwrite && paddr == `OFS_COND_CODES |-> prdata[6:5] == 2'h3)
    else $error("fixed flag bits not one");
  a_reset_vector: assert property (
    $rose(presetn) |-> mem_req && !mem_we && mem_addr == `VEC_RESET)
    else $error("reset vector not fetched");
  a_push_decrement: assert property (
    s_wr_ack ##1 (mem_req && mem_we) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("push address not decremented");
  a_pull_increment: assert property (
    s_rd_ack ##1 (mem_req && !mem_we) |-> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("pull address not incremented");
  a_swi_opcode: assert property (
    load_swi_ir |-> swi_opcode == `OPC_SWI && !exec_ready && mem_req && mem_we)
    else $error("wrong opcode at break");
  a_break_vector: assert property (
    load_swi_ir |-> ##[1:60] (mem_req && !mem_we &&
    mem_addr == (monitor_mode ? `VEC_SWI_MON : `VEC_SWI)))
    else $error("break vector not fetched");
  a_break_at_end: assert property (
    brk_match && insn_end && exec_ready |-> ##[1:2] load_swi_ir)
    else $error("break not started at instruction end");
  a_low_power_gate: assert property (
    exec_ready && cmd_valid && (cmd_code == 4'hC || cmd_code == 4'hD) |=> !cpu_clk_en)
    else $error("clock not gated in low power");
endmodule
bind cpu_prog_model cpu_prog_model_properties u_props (.pclk, .presetn, .psel, .pwrite,
  .paddr, .prdata, .exec_ready, .cmd_valid, .cmd_code, .insn_end, .brk_match, .monitor_mode,
  .mem_req, .mem_we, .mem_addr, .mem_ack, .cpu_clk_en, .load_swi_ir, .swi_opcode);

// *** test/tb_top.sv ***
// Self-checking bench for the programming-model block
`timescale 1ns/1ns
module tb_top;
  localparam STAB = 8;
  localparam [31:0] ALL = 32'hFFFFFFFF;
  localparam [1:0] CMD = 2'd0, ALU = 2'd1, FIN = 2'd2, EA = 2'd3;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg cmd_valid = 1'b0, alu_valid = 1'b0, insn_end = 1'b0, ea_req = 1'b0, ld, err;
  reg brk_match = 1'b0, monitor_mode = 1'b0, slow = 1'b0;
  reg [7:0] paddr = 8'h00, alu_operand = 8'h00, a, b, res, m, f;
  reg [31:0] pwdata = 32'h0, rv;
  reg [3:0] cmd_code = 4'h0, irq_pending = 4'h0;
  reg [15:0] cmd_data = 16'h0, ea_offset = 16'h0;
  reg [2:0] alu_op = 3'h0, op;
  reg [43:0] tab [0:9];
  wire [31:0] prdata;
  wire pready, pslverr, exec_ready, mem_req, mem_we, mem_ack, cpu_clk_en, load_swi_ir;
  wire [15:0] ea_addr, mem_addr;
  wire [7:0] mem_wdata, mem_rdata, swi_opcode;
  integer n_mismatch = 0, checks_done = 0, i, n;
  cpu_prog_model #(.STAB_CYCLES(STAB)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_ready, .cmd_valid, .cmd_code,
    .cmd_data, .alu_valid, .alu_op, .alu_operand, .insn_end, .ea_req, .ea_offset, .ea_addr,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .irq_pending,
    .brk_match, .monitor_mode, .cpu_clk_en, .load_swi_ir, .swi_opcode);
  mem_partner pm (.pclk, .presetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);
  initial begin
    forever #5 pclk = ~pclk;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] ad, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [31:0] mk, input [31:0] e);
    begin
      apb(1'b0, ad, 32'h0);
      chk(rv & mk, e);
    end
  endtask
  task wait_run;
    begin
      do begin
        @(posedge pclk);
      end while (exec_ready !== 1'b1);
    end
  endtask
  // One task for every execution-side request keeps the one-request-per-two-cycles spacing uniform
  task go(input [1:0] k, input [3:0] c, input [15:0] d);
    begin
      wait_run;
      cmd_valid <= (k == CMD);
      alu_valid <= (k == ALU);
      insn_end <= (k == FIN);
      ea_req <= (k == EA);
      cmd_code <= c;
      alu_op <= c[2:0];
      cmd_data <= d;
      alu_operand <= d[7:0];
      ea_offset <= d;
      @(posedge pclk);
      cmd_valid <= 1'b0;
      alu_valid <= 1'b0;
      insn_end <= 1'b0;
      ea_req <= 1'b0;
    end
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial begin
    tab[0] = 44'h87F01809794;
    tab[1] = 44'h8FF01009713;
    tab[2] = 44'h10001029700;
    tab[3] = 44'hA0001FF8705;
    tab[4] = 44'h30000FE8704;
    tab[5] = 44'hCF00F008602;
    tab[6] = 44'hD8001818604;
    tab[7] = 44'hE8100020701;
    tab[8] = 44'h80808101710;
    tab[9] = 44'h70000160700;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wait_run;
    rd(8'h04, ALL, 32'h00FF);
    rd(8'h08, ALL, 32'h4000);
    rd(8'h0C, 32'h68, 32'h68);
    apb(1'b1, 8'h0C, 32'h08);
    rd(8'h0C, 32'h68, 32'h68);
    apb(1'b0, 8'h20, 32'h0);
    chk(rv, 32'h0);
    chk({31'h0, err}, 32'h1);
    go(CMD, 4'h1, 16'hA55A);
    rd(8'h00, ALL, 32'hA55A);
    apb(1'b1, 8'h00, 32'h1234);
    rd(8'h00, ALL, 32'h1234);
    go(CMD, 4'h2, 16'h12F0);
    go(CMD, 4'h3, 16'h0);
    rd(8'h04, ALL, 32'h12FF);
    go(CMD, 4'h4, 16'h0);
    go(CMD, 4'h4, 16'h0);
    rd(8'h04, ALL, 32'h12FD);
    go(CMD, 4'h5, 16'h0);
    go(EA, 4'h0, 16'h0011);
    @(posedge pclk);
    chk(ea_addr, 32'h130F);
    go(CMD, 4'h7, 16'h2000);
    go(CMD, 4'h6, 16'h0);
    rd(8'h08, ALL, 32'h2001);
    for (i = 0; i < 10; i = i + 1) begin
      {ld, op, a, b, res, m, f} = tab[i];
      if (ld) go(CMD, 4'hF, {8'h00, a});
      go(ALU, {1'b0, op}, {8'h00, b});
      rd(8'h10, ALL, {24'h0, res});
      rd(8'h0C, {24'h0, m}, {24'h0, f});
    end
    go(CMD, 4'h2, 16'h00F0);
    go(CMD, 4'h7, 16'h1234);
    go(CMD, 4'hF, 16'h00A5);
    go(CMD, 4'h1, 16'h77C3);
    irq_pending <= 4'b0110;
    go(FIN, 4'h0, 16'h0);
    rd(8'h14, 32'hFF, 32'h02);
    go(CMD, 4'h8, 16'h0);
    go(FIN, 4'h0, 16'h0);
    wait_run;
    rd(8'h08, ALL, 32'h5100);
    rd(8'h04, ALL, 32'h00EB);
    rd(8'h0C, 32'h08, 32'h08);
    chk({pm.ram[16'h00F0], pm.ram[16'h00EF], pm.ram[16'h00EE], pm.ram[16'h00ED]},
      32'h3412C3A5);
    chk(pm.ram[16'h00EC] & 8'h68, 32'h60);
    irq_pending <= 4'b0000;
    go(CMD, 4'hB, 16'h0);
    wait_run;
    rd(8'h08, ALL, 32'h1234);
    rd(8'h04, ALL, 32'h00F0);
    rd(8'h0C, 32'h08, 32'h00);
    rd(8'h00, ALL, 32'h77C3);
    go(CMD, 4'h2, 16'h00E0);
    go(CMD, 4'hC, 16'h0);
    @(posedge pclk);
    chk(cpu_clk_en, 32'h0);
    irq_pending <= 4'b1000;
    wait_run;
    rd(8'h08, ALL, 32'h5200);
    chk(pm.ram[16'h00DC] & 8'h68, 32'h60);
    irq_pending <= 4'b0000;
    go(CMD, 4'hB, 16'h0);
    go(CMD, 4'h2, 16'h00D0);
    go(CMD, 4'hD, 16'h0);
    irq_pending <= 4'b0010;
    repeat (20) @(posedge pclk);
    chk(cpu_clk_en, 32'h0);
    irq_pending <= 4'b0011;
    n = 0;
    do begin
      @(posedge pclk);
      n = n + 1;
    end while (cpu_clk_en !== 1'b1 && n < 100);
    chk(n >= STAB, 32'h1);
    wait_run;
    rd(8'h08, ALL, 32'h5300);
    chk(pm.ram[16'h00CC] & 8'h68, 32'h60);
    irq_pending <= 4'b0000;
    go(CMD, 4'hB, 16'h0);
    slow <= 1'b1;
    monitor_mode <= 1'b1;
    brk_match <= 1'b1;
    go(FIN, 4'h0, 16'h0);
    wait_run;
    rd(8'h08, ALL, 32'h6000);
    go(CMD, 4'hB, 16'h0);
    repeat (40) @(posedge pclk);
    rd(8'h14, 32'hFF, 32'h80);
    brk_match <= 1'b0;
    wait_run;
    rd(8'h14, 32'hFF, 32'h02);
    monitor_mode <= 1'b0;
    go(CMD, 4'hE, 16'h0);
    wait_run;
    rd(8'h08, ALL, 32'h7000);
    go(CMD, 4'h8, 16'h0);
    go(CMD, 4'hC, 16'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    wait_run;
    rd(8'h0C, 32'h08, 32'h08);
    rd(8'h04, ALL, 32'h00FF);
    go(CMD, 4'hA, 16'h00FF);
    rd(8'h0C, ALL, 32'hFF);
    go(CMD, 4'hA, 16'h0000);
    rd(8'h0C, ALL, 32'h68);
    apb(1'b1, 8'h0C, 32'h00);
    rd(8'h0C, ALL, 32'h68);
    go(CMD, 4'h8, 16'h0);
    rd(8'h0C, 32'h08, 32'h00);
    go(CMD, 4'h9, 16'h0);
    rd(8'h0C, 32'h08, 32'h08);
    final_report;
  end
endmodule
